// [src/fspw_writer.sv]
`timescale 1ns/1ns
`default_nettype none
module fspw_writer #(
   parameter int PROG_CYCLES = fspw_pkg::PROG_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic [4:0] i_awaddr,
   input wire logic i_awvalid,
   output logic o_awready,
   input wire logic [31:0] i_wdata,
   input wire logic [3:0] i_wstrb,
   input wire logic i_wvalid,
   output logic o_wready,
   output logic [1:0] o_bresp,
   output logic o_bvalid,
   input wire logic i_bready,
   input wire logic [4:0] i_araddr,
   input wire logic i_arvalid,
   output logic o_arready,
   output logic [31:0] o_rdata,
   output logic [1:0] o_rresp,
   output logic o_rvalid,
   input wire logic i_rready,
   output logic o_cpu_stall,
   output logic o_flash_prog,
   output logic o_flash_word_mode,
   output logic [11:0] o_flash_block,
   output logic [5:0] o_flash_offset,
   output logic [511:0] o_flash_data
);
   logic [7:0] hold_reg [fspw_pkg::HOLD_COUNT];
   logic [fspw_pkg::PTR_W-1:0] table_pointer;
   logic [7:0] table_latch;
   logic [7:0] irq_ctrl;
   logic single_word_mode_bit;
   logic erase_bit;
   logic program_enable_bit;
   logic program_error_flag;
   logic busy;
   logic [31:0] prog_cnt;
   fspw_pkg::fspw_key_e key_state;
   logic aw_held, w_held;
   logic [4:0] aw_addr;
   logic [31:0] w_data;
   logic [3:0] w_strb;
   logic wr_fire;
   logic [7:0] wr_byte;
   logic store_fire;
   logic [fspw_pkg::PTR_W-1:0] next_ptr;
   logic [fspw_pkg::PTR_W-1:0] store_ptr;
   logic start_req;
   logic prog_done;

   // write channel: both halves may arrive in either order
   assign o_awready = !aw_held && !o_bvalid;
   assign o_wready = !w_held && !o_bvalid;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= '0;
         w_data <= '0;
         w_strb <= '0;
      end
      else if (wr_fire)
      begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_held <= 1'b1;
            aw_addr <= i_awaddr;
         end
         if (i_wvalid && o_wready)
         begin
            w_held <= 1'b1;
            w_data <= i_wdata;
            w_strb <= i_wstrb;
         end
      end
   end

   // writes land while the cpu stalls would be impossible; hold them off
   assign wr_fire = aw_held && w_held && !busy;
   assign wr_byte = w_strb[0] ? w_data[7:0] : 8'h00;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_bvalid <= 1'b0;
         o_bresp <= fspw_pkg::RESP_OKAY;
      end
      else if (wr_fire)
      begin
         o_bvalid <= 1'b1;
         o_bresp <= (aw_addr > fspw_pkg::ADDR_STORE || aw_addr[1:0] != 2'h0) ?
                    fspw_pkg::RESP_SLVERR : fspw_pkg::RESP_OKAY;
      end
      else if (i_bready)
      begin
         o_bvalid <= 1'b0;
      end
   end

   // table store op
   assign store_fire = wr_fire && aw_addr == fspw_pkg::ADDR_STORE && w_strb[0];

   always_comb
   begin
      next_ptr = table_pointer;
      store_ptr = table_pointer;
      unique case (w_data[1:0])
         fspw_pkg::OP_PLAIN: next_ptr = table_pointer;
         fspw_pkg::OP_POST_INC: next_ptr = table_pointer + 22'h1;
         fspw_pkg::OP_POST_DEC: next_ptr = table_pointer - 22'h1;
         fspw_pkg::OP_PRE_INC:
         begin
            next_ptr = table_pointer + 22'h1;
            store_ptr = next_ptr;
         end
      endcase
      // pointer steps touch only the low 21 bits
      next_ptr[fspw_pkg::PTR_W-1] = table_pointer[fspw_pkg::PTR_W-1];
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         table_pointer <= '0;
      end
      else if (store_fire)
      begin
         table_pointer <= next_ptr;
      end
      else if (wr_fire)
      begin
         unique case (aw_addr)
            fspw_pkg::ADDR_PTR_UPPER: table_pointer[21:16] <= wr_byte[5:0];
            fspw_pkg::ADDR_PTR_HIGH: table_pointer[15:8] <= wr_byte;
            fspw_pkg::ADDR_PTR_LOW: table_pointer[7:0] <= wr_byte;
            default: table_pointer <= table_pointer;
         endcase
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         table_latch <= '0;
         irq_ctrl <= '0;
      end
      else if (wr_fire && aw_addr == fspw_pkg::ADDR_LATCH)
      begin
         table_latch <= wr_byte;
      end
      else if (wr_fire && aw_addr == fspw_pkg::ADDR_IRQ_CTRL)
      begin
         irq_ctrl <= wr_byte;
      end
   end

   // holding registers are never cleared by programming; only reset clears them
   generate
      for (genvar g = 0; g < fspw_pkg::HOLD_COUNT; g++)
      begin : g_hold
         always_ff @(posedge i_clk_sys or negedge i_rst_n)
         begin
            if (!i_rst_n)
            begin
               hold_reg[g] <= '0;
            end
            else if (store_fire && store_ptr[fspw_pkg::HOLD_IDX_W-1:0] == 6'(g))
            begin
               hold_reg[g] <= table_latch;
            end
         end
         assign o_flash_data[g*8 +: 8] = hold_reg[g];
      end
   endgenerate

   // unlock: 55h then aah with no other write in between
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         key_state <= fspw_pkg::KEY_IDLE;
      end
      else if (wr_fire)
      begin
         if (aw_addr == fspw_pkg::ADDR_KEY && wr_byte == fspw_pkg::KEY_FIRST)
         begin
            key_state <= fspw_pkg::KEY_ARMED;
         end
         else if (aw_addr == fspw_pkg::ADDR_KEY && wr_byte == fspw_pkg::KEY_SECOND &&
                  key_state == fspw_pkg::KEY_ARMED)
         begin
            key_state <= fspw_pkg::KEY_OPEN;
         end
         else
         begin
            key_state <= fspw_pkg::KEY_IDLE;
         end
      end
   end

   assign start_req = wr_fire && aw_addr == fspw_pkg::ADDR_CTRL && wr_byte[fspw_pkg::CTRL_START] &&
                      key_state == fspw_pkg::KEY_OPEN &&
                      wr_byte[fspw_pkg::CTRL_ENABLE] && program_enable_bit;
   assign prog_done = busy && prog_cnt == PROG_CYCLES - 1;

   // long write: self-timed, start bit set-only and cleared at completion
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         busy <= 1'b0;
         prog_cnt <= '0;
      end
      else if (start_req)
      begin
         busy <= 1'b1;
         prog_cnt <= '0;
      end
      else if (prog_done)
      begin
         busy <= 1'b0;
         prog_cnt <= '0;
      end
      else if (busy)
      begin
         prog_cnt <= prog_cnt + 32'h1;
      end
   end

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         single_word_mode_bit <= 1'b0;
         erase_bit <= 1'b0;
         program_enable_bit <= 1'b0;
      end
      else if (wr_fire && aw_addr == fspw_pkg::ADDR_CTRL)
      begin
         single_word_mode_bit <= wr_byte[fspw_pkg::CTRL_WORD_MODE];
         erase_bit <= wr_byte[fspw_pkg::CTRL_ERASE];
         program_enable_bit <= wr_byte[fspw_pkg::CTRL_ENABLE];
      end
   end

   // error flag has no reset: a write cut short by any reset leaves it set
   always_ff @(posedge i_clk_sys)
   begin
      if (start_req)
      begin
         program_error_flag <= 1'b1;
      end
      else if (prog_done)
      begin
         program_error_flag <= 1'b0;
      end
      else if (wr_fire && aw_addr == fspw_pkg::ADDR_CTRL)
      begin
         program_error_flag <= wr_byte[fspw_pkg::CTRL_ERR];
      end
   end

   // flash side
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_flash_prog <= 1'b0;
         o_flash_word_mode <= 1'b0;
         o_flash_block <= '0;
         o_flash_offset <= '0;
      end
      else if (start_req)
      begin
         o_flash_prog <= !erase_bit;
         o_flash_word_mode <= single_word_mode_bit;
         o_flash_block <= table_pointer[fspw_pkg::PTR_BLOCK_MSB:fspw_pkg::PTR_BLOCK_LSB];
         o_flash_offset <= single_word_mode_bit ? {table_pointer[5:1], 1'b0} : 6'h00;
      end
      else if (prog_done)
      begin
         o_flash_prog <= 1'b0;
      end
   end

   assign o_cpu_stall = busy;

   // read channel
   assign o_arready = !o_rvalid;

   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         o_rvalid <= 1'b0;
         o_rdata <= '0;
         o_rresp <= fspw_pkg::RESP_OKAY;
      end
      else if (i_arvalid && o_arready)
      begin
         o_rvalid <= 1'b1;
         o_rresp <= fspw_pkg::RESP_OKAY;
         o_rdata <= '0;
         unique case (i_araddr)
            fspw_pkg::ADDR_PTR_UPPER: o_rdata[7:0] <= {2'h0, table_pointer[21:16]};
            fspw_pkg::ADDR_PTR_HIGH: o_rdata[7:0] <= table_pointer[15:8];
            fspw_pkg::ADDR_PTR_LOW: o_rdata[7:0] <= table_pointer[7:0];
            fspw_pkg::ADDR_LATCH: o_rdata[7:0] <= table_latch;
            fspw_pkg::ADDR_IRQ_CTRL: o_rdata[7:0] <= irq_ctrl;
            fspw_pkg::ADDR_KEY: o_rdata[7:0] <= 8'h00;
            fspw_pkg::ADDR_CTRL: o_rdata[7:0] <= {2'h0, single_word_mode_bit, erase_bit,
                                                   program_error_flag, program_enable_bit, busy, 1'b0};
            fspw_pkg::ADDR_STORE: o_rdata[7:0] <= 8'h00;
            default: o_rresp <= fspw_pkg::RESP_SLVERR;
         endcase
      end
      else if (i_rready)
      begin
         o_rvalid <= 1'b0;
      end
   end
endmodule // fspw_writer
`default_nettype wire

// [src/fspw_pkg.sv]
`default_nettype none
package fspw_pkg;
   // register byte offsets on the bus
   localparam logic [4:0] ADDR_PTR_UPPER = 5'h00;
   localparam logic [4:0] ADDR_PTR_HIGH = 5'h04;
   localparam logic [4:0] ADDR_PTR_LOW = 5'h08;
   localparam logic [4:0] ADDR_LATCH = 5'h0c;
   localparam logic [4:0] ADDR_IRQ_CTRL = 5'h10;
   localparam logic [4:0] ADDR_KEY = 5'h14;
   localparam logic [4:0] ADDR_CTRL = 5'h18;
   localparam logic [4:0] ADDR_STORE = 5'h1c;
   // table store op word: bits 1:0 pointer mode
   localparam logic [1:0] OP_PLAIN = 2'h0;
   localparam logic [1:0] OP_POST_INC = 2'h1;
   localparam logic [1:0] OP_POST_DEC = 2'h2;
   localparam logic [1:0] OP_PRE_INC = 2'h3;
   // control register fields
   localparam int CTRL_WORD_MODE = 5;
   localparam int CTRL_ERASE = 4;
   localparam int CTRL_ERR = 3;
   localparam int CTRL_ENABLE = 2;
   localparam int CTRL_START = 1;
   localparam logic [7:0] CTRL_RW_MASK = 8'h34;
   localparam logic [7:0] KEY_FIRST = 8'h55;
   localparam logic [7:0] KEY_SECOND = 8'haa;
   localparam int HOLD_COUNT = 64;
   localparam int HOLD_IDX_W = 6;
   localparam int PTR_W = 22;
   localparam int PTR_BLOCK_LSB = 10;
   localparam int PTR_BLOCK_MSB = 21;
   localparam logic [7:0] PTR_UPPER_MASK = 8'h3f;
   // programming time
   localparam int PROG_TIME_US = 1000;
   localparam int CLK_MHZ = 10;
   localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;
   typedef enum logic [1:0] {KEY_IDLE, KEY_ARMED, KEY_OPEN} fspw_key_e;
endpackage
`default_nettype wire

// [verification/fspw_writer_chk.sv]
`timescale 1ns/1ns
`default_nettype none
module fspw_writer_chk #(
   parameter int PROG_CYCLES = fspw_pkg::PROG_CYCLES
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_n,
   input wire logic o_awready,
   input wire logic o_wready,
   input wire logic o_bvalid,
   input wire logic i_bready,
   input wire logic o_cpu_stall,
   input wire logic o_flash_prog,
   input wire logic o_flash_word_mode,
   input wire logic [11:0] o_flash_block,
   input wire logic [5:0] o_flash_offset
);
   int cnt;
   default clocking @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_n);
   // counter instead of a repetition: the write length is a parameter
   always_ff @(posedge i_clk_sys or negedge i_rst_n)
   begin
      if (!i_rst_n)
         cnt <= 0;
      else
         cnt <= o_cpu_stall ? cnt + 1 : 0;
   end
   property p_len; $fell(o_cpu_stall) |-> cnt == PROG_CYCLES; endproperty
   a_len: assert property (p_len) else $error("long write length wrong");
   property p_max; o_cpu_stall |-> cnt < PROG_CYCLES; endproperty
   a_max: assert property (p_max) else $error("long write overruns timer");
   property p_prog; o_flash_prog |-> o_cpu_stall; endproperty
   a_prog: assert property (p_prog) else $error("programming without stall");
   property p_blk; o_cpu_stall && cnt > 1 |-> $stable(o_flash_block); endproperty
   a_blk: assert property (p_blk) else $error("block moved during write");
   property p_mode; o_cpu_stall && cnt > 1 |-> $stable(o_flash_word_mode) && $stable(o_flash_offset); endproperty
   a_mode: assert property (p_mode) else $error("mode moved during write");
   property p_off; o_flash_prog && !o_flash_word_mode |-> o_flash_offset == 6'h0; endproperty
   a_off: assert property (p_off) else $error("offset set in block mode");
   property p_bhold; $fell(o_bvalid) |-> $past(i_bready); endproperty
   a_bhold: assert property (p_bhold) else $error("write response dropped without ready");
   property p_bblk; o_bvalid |-> !o_awready && !o_wready; endproperty
   a_bblk: assert property (p_bblk) else $error("new write taken before response");
   c_blk: cover property ($rose(o_cpu_stall) && !o_flash_word_mode);
   c_wd: cover property ($rose(o_cpu_stall) && o_flash_word_mode);
   c_end: cover property ($fell(o_cpu_stall));
endmodule // fspw_writer_chk
bind fspw_writer fspw_writer_chk #(.PROG_CYCLES(PROG_CYCLES)) fspw_writer_chk_i (.*);
`default_nettype wire

// [verification/tb.sv]
`timescale 1ns/1ns
`default_nettype none
module tb;
   localparam int PC = 20;
   logic i_clk_sys = 1'h0, i_rst_n = 1'h0, i_awvalid = 1'h0, i_wvalid = 1'h0, i_bready = 1'h0;
   logic i_arvalid = 1'h0, i_rready = 1'h0, sq = 1'h0;
   logic [4:0] i_awaddr = 5'h0, i_araddr = 5'h0;
   logic [31:0] i_wdata = 32'h0, o_rdata;
   logic [3:0] i_wstrb = 4'hf;
   logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_cpu_stall, o_flash_prog, o_flash_word_mode;
   logic [1:0] o_bresp, o_rresp;
   logic [11:0] o_flash_block;
   logic [5:0] o_flash_offset;
   logic [511:0] o_flash_data, exp_data = 512'h0;
   logic [13:0] snap = 14'h0;
   int n_mismatch = 0, checks_done = 0, ns = 0;
   always #50 i_clk_sys = ~i_clk_sys;
   fspw_writer #(.PROG_CYCLES(PC)) fspw_writer_i (.*);
   // mode and block are taken at launch, so snapshot them there
   always @(posedge i_clk_sys)
   begin
      sq <= o_cpu_stall;
      if (o_cpu_stall === 1'h1)
         ns <= ns + 1;
      if (o_cpu_stall && !sq)
         snap <= {o_flash_word_mode, o_flash_prog, o_flash_block};
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("[FAIL] %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic bnd(input int n);
      chk("wait_bound", 32'h0, 32'(n / 200));
      if (n >= 200)
         tally_and_finish();
   endtask
   // one transfer; response ready goes up with the request and stays until valid is seen
   task automatic io(input logic w, input logic [4:0] a, input logic [7:0] d, input logic [31:0] m = 32'h0,
         input logic [31:0] e = 32'h0, input logic [1:0] er = fspw_pkg::RESP_OKAY);
      int n;
      n = 0;
      i_awaddr <= a;
      i_araddr <= a;
      i_wdata <= {24'h0, d};
      i_awvalid <= w;
      i_wvalid <= w;
      i_arvalid <= !w;
      i_bready <= w;
      i_rready <= !w;
      do
      begin
         @(posedge i_clk_sys);
         n++;
         if (o_awready && i_awvalid)
            i_awvalid <= 1'h0;
         if (o_wready && i_wvalid)
            i_wvalid <= 1'h0;
         if (o_arready && i_arvalid)
            i_arvalid <= 1'h0;
      end
      while ((i_awvalid || i_wvalid || i_arvalid || (w ? o_bvalid : o_rvalid) !== 1'h1) && n < 200);
      bnd(n);
      chk($sformatf("resp_%h", a), {30'h0, er}, {30'h0, (w ? o_bresp : o_rresp)});
      chk($sformatf("rdata_%h", a), e, o_rdata & m);
      i_bready <= 1'h0;
      i_rready <= 1'h0;
      @(posedge i_clk_sys);
   endtask
   task automatic go(input logic [7:0] pre, input logic [7:0] c);
      io(1'h1, fspw_pkg::ADDR_IRQ_CTRL, 8'h00);
      io(1'h1, fspw_pkg::ADDR_CTRL, pre);
      io(1'h1, fspw_pkg::ADDR_KEY, fspw_pkg::KEY_FIRST);
      io(1'h1, fspw_pkg::ADDR_KEY, fspw_pkg::KEY_SECOND);
      io(1'h1, fspw_pkg::ADDR_CTRL, c);
   endtask
   task automatic wl();
      int n;
      n = 0;
      while (o_cpu_stall !== 1'h0 && n < 200)
      begin
         @(posedge i_clk_sys);
         n++;
      end
      bnd(n);
   endtask
   task automatic cd();
      for (int j = 0; j < 16; j++)
         chk("hold", exp_data[j*32+:32], o_flash_data[j*32+:32]);
   endtask
   initial
   begin
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'h1;
      @(posedge i_clk_sys);
      io(1'h1, fspw_pkg::ADDR_PTR_UPPER, 8'hff);
      io(1'h0, fspw_pkg::ADDR_PTR_UPPER, 8'h0, 32'hffffffff, 32'h3f);
      io(1'h1, fspw_pkg::ADDR_KEY, 8'h55);
      io(1'h0, fspw_pkg::ADDR_KEY, 8'h0, 32'hffffffff, 32'h0);
      io(1'h1, 5'h02, 8'h11, 32'h0, 32'h0, fspw_pkg::RESP_SLVERR);
      io(1'h0, 5'h02, 8'h0, 32'hffffffff, 32'h0, fspw_pkg::RESP_SLVERR);
      io(1'h1, fspw_pkg::ADDR_PTR_UPPER, 8'h00);
      io(1'h1, fspw_pkg::ADDR_PTR_HIGH, 8'h03);
      io(1'h1, fspw_pkg::ADDR_PTR_LOW, 8'hff);
      for (int k = 0; k < 64; k++)
      begin
         exp_data[k*8+:8] = 8'(k * 7 + 1);
         io(1'h1, fspw_pkg::ADDR_LATCH, exp_data[k*8+:8]);
         io(1'h1, fspw_pkg::ADDR_STORE, {6'h0, fspw_pkg::OP_PRE_INC});
      end
      io(1'h1, fspw_pkg::ADDR_CTRL, 8'h04);
      io(1'h1, fspw_pkg::ADDR_KEY, fspw_pkg::KEY_FIRST);
      io(1'h1, fspw_pkg::ADDR_PTR_LOW, 8'h3f);
      io(1'h1, fspw_pkg::ADDR_KEY, fspw_pkg::KEY_SECOND);
      io(1'h1, fspw_pkg::ADDR_CTRL, 8'h06);
      go(8'h00, 8'h06);
      repeat (3) @(posedge i_clk_sys);
      chk("no_stall", 32'h0, 32'(ns));
      go(8'h04, 8'h06);
      io(1'h0, fspw_pkg::ADDR_CTRL, 8'h0, 32'h3e, 32'h0e);
      wl();
      io(1'h0, fspw_pkg::ADDR_CTRL, 8'h0, 32'h3e, 32'h04);
      chk("blk_off", 32'h0, {26'h0, o_flash_offset});
      io(1'h1, fspw_pkg::ADDR_IRQ_CTRL, 8'h80);
      io(1'h0, fspw_pkg::ADDR_IRQ_CTRL, 8'h0, 32'hff, 32'h80);
      chk("stall_len", 32'(PC), 32'(ns));
      chk("blk_mode", 32'h1001, {18'h0, snap});
      cd();
      io(1'h1, fspw_pkg::ADDR_PTR_HIGH, 8'h08);
      io(1'h1, fspw_pkg::ADDR_PTR_LOW, 8'h02);
      for (int k = 2; k < 4; k++)
      begin
         exp_data[k*8+:8] = 8'(k * 16 + 5);
         io(1'h1, fspw_pkg::ADDR_LATCH, exp_data[k*8+:8]);
         io(1'h1, fspw_pkg::ADDR_STORE, {6'h0, (k == 2) ? fspw_pkg::OP_POST_INC : fspw_pkg::OP_PLAIN});
      end
      go(8'h24, 8'h26);
      wl();
      chk("word_mode", 32'h3002, {18'h0, snap});
      chk("word_off", 32'h2, {26'h0, o_flash_offset});
      chk("stall_len2", 32'(2 * PC), 32'(ns));
      cd();
      go(8'h14, 8'h16);
      wl();
      chk("erase_mode", 32'h0002, {18'h0, snap});
      chk("stall_len3", 32'(3 * PC), 32'(ns));
      go(8'h04, 8'h06);
      i_rst_n <= 1'h0;
      repeat (2) @(posedge i_clk_sys);
      i_rst_n <= 1'h1;
      @(posedge i_clk_sys);
      io(1'h0, fspw_pkg::ADDR_CTRL, 8'h0, 32'h0e, 32'h08);
      exp_data = 512'h0;
      cd();
      tally_and_finish();
   end
endmodule // tb
`default_nettype wire
